/* core/ebu_top.sv */
// External bus unit: chip selects, bus sizing, boot source, watchdog.
// Assumes a core bus on clock_i and asynchronous external pins.
//
// Behaviour
// - 22-bit external address bus and 16-bit two-way data bus.
// - address low in reset; address and data hold last values when idle.
// - read/write pin high for read, low for write, high in reset.
// - upper lane enable low for upper lane, lower for lower; high in reset.
// - output enable low only during reads; high in reset.
// - six 16-Mbyte regions, top byte 40h to 45h select zero to five.
// - only lowest 4 Mbytes reachable; higher offsets wrap, software avoids them.
// - selects zero to four assert low, five asserts high on match.
// - after reset selects one-four drive high, five low, as outputs.
// - chip select zero resets to 15 wait states and 16-bit port.
// - boot select low: ROM off first cycle, select zero, vector 40000000h.
// - boot select high: ROM stays on, vector from address zero.
// - byte, halfword, word to 8- and 16-bit ports; misaligned refused.
// - port width per select; 8-bit port on upper or lower lane.
// - width 00 upper 8-bit, 01 lower 8-bit, 10 16-bit, 11 reserved.
// - word/8-bit four cycles, word/16-bit two, halfword/8-bit two.
// - low two address bits step for each following bus cycle.
// - bytes big-endian onto lanes; 16-bit even upper, odd lower.
// - size code 01 byte, 10 halfword, 00 word steers active lanes.
// - no acknowledge in 128 clocks ends access, then error acknowledge.
// - watchdog restarts after each access; unmapped accesses time out.
`timescale 1ns/1ns
`default_nettype none

module ebu_top
  import ebu_pkg::*;
(
  // Clock and reset.
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  // Core request.
  input  wire logic        req_i,
  input  wire logic [31:0] addr_i,
  input  wire logic        write_i,
  input  wire ebu_size_t   size_i,
  input  wire logic [31:0] wdata_i,
  output logic             req_ready_o,
  // Core answer.
  output logic             ack_o,
  output logic             err_o,
  output logic [31:0]      rdata_o,
  // Chip select configuration.
  input  wire logic        cfg_load_i,
  input  wire logic [2:0]  cfg_sel_i,
  input  wire logic        cfg_enable_i,
  input  wire logic        cfg_gpo_i,
  input  wire ebu_width_t  cfg_width_i,
  input  wire logic [3:0]  cfg_wait_i,
  // Boot control.
  input  wire logic        boot_select_i,
  output logic             rom_enable_o,
  output logic [31:0]      reset_vector_o,
  // External bus pins.
  output logic [21:0]      ext_addr_o,
  input  wire logic [15:0] ext_data_i,
  output logic [15:0]      ext_data_o,
  output logic             ext_data_oe_o,
  input  wire logic        ext_ready_i,
  output logic             read_write_n_o,
  output logic             output_enable_n_o,
  output logic             upper_lane_enable_n_o,
  output logic             lower_lane_enable_n_o,
  output logic [4:0]       chip_select_n_o,
  output logic             chip_select_five_o
);

`include "ebu_regs.svh"

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions.

  function automatic logic [2:0] cs_decode(input logic [31:0] a);
    logic [7:0] diff;
    diff = a[31:24] - `EBU_CS_BASE;
    if (a[31:24] >= `EBU_CS_BASE && diff < {5'h00, `EBU_NUM_CS}) begin
      cs_decode = diff[2:0];
    end else begin
      cs_decode = `EBU_NO_CS;
    end
  endfunction

  function automatic logic misaligned(input ebu_size_t s, input logic [1:0] a);
    unique case (s)
      EBU_SZ_BYTE: misaligned = 1'b0;
      EBU_SZ_HALF: misaligned = a[0];
      EBU_SZ_WORD: misaligned = |a;
      default:     misaligned = 1'b1;
    endcase
  endfunction

  function automatic logic [7:0] get_byte(input logic [31:0] w, input logic [1:0] i);
    get_byte = w[(5'd24 - {i, 3'b000}) +: 8];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.

  ebu_state_t  state;
  logic [5:0]  cs_enable;
  logic [5:0]  cs_gpo;
  ebu_width_t  cs_width [6];
  logic [3:0]  cs_wait  [6];
  logic        cur_mapped;
  logic [2:0]  cur_cs;
  logic        cur_write;
  ebu_size_t   cur_size;
  logic [1:0]  cur_addr_lo;
  logic [19:0] cur_addr_hi;
  logic [31:0] cur_wdata;
  logic [1:0]  beat;
  logic [3:0]  wait_count;
  logic        resp_err;
  logic [31:0] rdata;
  logic [21:0] addr_q;
  logic [15:0] data_q;
  logic        ready_s1;
  logic        ready_s2;
  logic [15:0] din_s1;
  logic [15:0] din_s2;
  logic        boot_s1;
  logic        boot_s2;
  logic        boot_select;
  logic        first_cycle;
  logic        accept;
  logic [2:0]  req_cs;
  logic        req_bad;
  logic        on_bus;
  logic        beat_done;
  logic        last_beat;
  logic        expire;
  ebu_width_t  cur_width;
  logic [3:0]  cur_wait;
  logic [2:0]  beats;
  logic [1:0]  ext_lo;
  logic        upper_en;
  logic        lower_en;
  logic [1:0]  upper_byte;
  logic [1:0]  lower_byte;
  logic [5:0]  cs_pin;

  ////////////////////////////////////////////////////////////////////////////
  // Request decode.

  assign req_ready_o = (state == EBU_ST_IDLE);
  assign accept      = req_i && req_ready_o;
  assign req_cs      = cs_decode(addr_i);
  assign req_bad     = (req_cs != `EBU_NO_CS) && (!cs_enable[req_cs]
                       || misaligned(size_i, addr_i[1:0])
                       || cs_width[req_cs] == EBU_W_RSVD);
  assign cur_width   = cur_mapped ? cs_width[cur_cs] : EBU_W16;
  assign cur_wait    = cur_mapped ? cs_wait[cur_cs] : 4'h0;
  assign on_bus      = (state == EBU_ST_BEAT) && cur_mapped;
  assign beat_done   = on_bus && (wait_count == cur_wait) && ready_s2;
  assign last_beat   = ({1'b0, beat} + 3'h1) == beats;

  ebu_lane_steer u_steer (
    .size_i       (cur_size),
    .addr_lo_i    (cur_addr_lo),
    .width_i      (cur_width),
    .beat_i       (beat),
    .beats_o      (beats),
    .ext_addr_o   (ext_lo),
    .upper_en_o   (upper_en),
    .lower_en_o   (lower_en),
    .upper_byte_o (upper_byte),
    .lower_byte_o (lower_byte)
  );

  ebu_watchdog u_wdog (
    .clock_i  (clock_i),
    .rst_n_i  (rst_n_i),
    .start_i  (accept),
    .stop_i   (state == EBU_ST_DONE),
    .expire_o (expire)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      ready_s1 <= 1'b0;
      ready_s2 <= 1'b0;
      din_s1   <= 16'h0000;
      din_s2   <= 16'h0000;
      boot_s1  <= boot_select_i;
      boot_s2  <= boot_s1;
    end else begin
      ready_s1 <= ext_ready_i;
      ready_s2 <= ready_s1 && on_bus;
      din_s1   <= ext_data_i;
      din_s2   <= din_s1;
      boot_s1  <= boot_select_i;
      boot_s2  <= boot_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Boot source.

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      boot_select <= boot_s2;
      first_cycle <= 1'b1;
    end else begin
      first_cycle <= 1'b0;
    end
  end

  assign rom_enable_o   = !(first_cycle && !boot_select);
  assign reset_vector_o = boot_select ? `EBU_VEC_INTERNAL : `EBU_VEC_EXTERNAL;

  ////////////////////////////////////////////////////////////////////////////
  // Chip select configuration.

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      cs_enable <= `EBU_RST_ENABLE;
      cs_gpo    <= `EBU_RST_GPO;
      for (int i = 0; i < 6; i++) begin
        cs_width[i] <= ebu_width_t'(`EBU_RST_WIDTH);
        cs_wait[i]  <= (i == 0) ? `EBU_RST_WAIT_CS0 : `EBU_RST_WAIT_CSN;
      end
    end else if (cfg_load_i && cfg_sel_i < `EBU_NUM_CS) begin
      cs_enable[cfg_sel_i] <= cfg_enable_i;
      cs_gpo[cfg_sel_i]    <= cfg_gpo_i;
      cs_width[cfg_sel_i]  <= cfg_width_i;
      cs_wait[cfg_sel_i]   <= cfg_wait_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transfer sequencer.

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      state      <= EBU_ST_IDLE;
      beat       <= 2'h0;
      wait_count <= 4'h0;
      resp_err   <= 1'b0;
    end else begin
      unique case (state)
        EBU_ST_IDLE: begin
          if (accept) begin
            beat       <= 2'h0;
            wait_count <= 4'h0;
            resp_err   <= req_bad;
            state      <= req_bad ? EBU_ST_DONE : EBU_ST_ADDR;
          end
        end
        EBU_ST_ADDR: begin
          state <= EBU_ST_BEAT;
        end
        EBU_ST_BEAT: begin
          if (expire) begin
            resp_err <= 1'b1;
            state    <= EBU_ST_DONE;
          end else if (beat_done) begin
            wait_count <= 4'h0;
            if (last_beat) begin
              state <= EBU_ST_DONE;
            end else begin
              beat  <= beat + 2'h1;
              state <= EBU_ST_ADDR;
            end
          end else if (on_bus && wait_count != cur_wait) begin
            wait_count <= wait_count + 4'h1;
          end
        end
        EBU_ST_DONE: begin
          state <= EBU_ST_IDLE;
        end
      endcase
      if (expire && state != EBU_ST_BEAT) begin
        resp_err <= 1'b1;
        state    <= EBU_ST_DONE;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      cur_mapped  <= 1'b0;
      cur_cs      <= `EBU_NO_CS;
      cur_write   <= 1'b0;
      cur_size    <= EBU_SZ_WORD;
      cur_addr_lo <= 2'h0;
      cur_addr_hi <= 20'h00000;
      cur_wdata   <= 32'h0000_0000;
    end else if (accept) begin
      cur_mapped  <= (req_cs != `EBU_NO_CS);
      cur_cs      <= req_cs;
      cur_write   <= write_i;
      cur_size    <= size_i;
      cur_addr_lo <= addr_i[1:0];
      cur_addr_hi <= addr_i[21:2];
      cur_wdata   <= wdata_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address and data pins, held between accesses.

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      addr_q <= 22'h000000;
    end else if (state == EBU_ST_ADDR && cur_mapped) begin
      addr_q <= {cur_addr_hi, ext_lo};
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      data_q <= 16'h0000;
    end else if (state == EBU_ST_ADDR && cur_mapped && cur_write) begin
      if (upper_en) begin
        data_q[15:8] <= get_byte(cur_wdata, upper_byte);
      end
      if (lower_en) begin
        data_q[7:0] <= get_byte(cur_wdata, lower_byte);
      end
    end
  end

  assign ext_addr_o    = addr_q;
  assign ext_data_o    = data_q;
  assign ext_data_oe_o = on_bus && cur_write;

  ////////////////////////////////////////////////////////////////////////////
  // Read data assembly and answer.

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      rdata <= 32'h0000_0000;
    end else if (beat_done && !cur_write) begin
      if (upper_en) begin
        rdata[(5'd24 - {upper_byte, 3'b000}) +: 8] <= din_s2[15:8];
      end
      if (lower_en) begin
        rdata[(5'd24 - {lower_byte, 3'b000}) +: 8] <= din_s2[7:0];
      end
    end
  end

  assign rdata_o = rdata;
  assign ack_o   = (state == EBU_ST_DONE) && !resp_err;
  assign err_o   = (state == EBU_ST_DONE) && resp_err;

  ////////////////////////////////////////////////////////////////////////////
  // Strobes and chip selects.

  assign read_write_n_o        = !(on_bus && cur_write);
  assign output_enable_n_o     = !(on_bus && !cur_write);
  assign upper_lane_enable_n_o = !(on_bus && upper_en);
  assign lower_lane_enable_n_o = !(on_bus && lower_en);

  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (!cs_enable[i]) begin
        cs_pin[i] = cs_gpo[i];
      end else if (i == 5) begin
        cs_pin[i] = on_bus && cur_cs == 3'(i);
      end else begin
        cs_pin[i] = !((on_bus && cur_cs == 3'(i))
                      || (i == 0 && first_cycle && !boot_select));
      end
    end
  end

  assign chip_select_n_o    = cs_pin[4:0];
  assign chip_select_five_o = cs_pin[5];

endmodule

`default_nettype wire

/* core/ebu_regs.svh */
// Constants of the external bus unit: decode, reset values, timing.
// Assumes inclusion by every file that uses them, by bare name.
`ifndef EBU_REGS_SVH
`define EBU_REGS_SVH

`define EBU_CS_BASE        8'h40
`define EBU_NUM_CS         3'h6
`define EBU_NO_CS          3'h7
`define EBU_WDOG_CLOCKS    8'h80
`define EBU_VEC_EXTERNAL   32'h4000_0000
`define EBU_VEC_INTERNAL   32'h0000_0000
`define EBU_RST_ENABLE     6'h01
`define EBU_RST_GPO        6'h1f
`define EBU_RST_WAIT_CS0   4'hf
`define EBU_RST_WAIT_CSN   4'h0
`define EBU_RST_WIDTH      2'h2

`endif

/* core/ebu_pkg.sv */
// Types of the external bus unit.
// Assumes nothing of its surroundings.
package ebu_pkg;

  typedef enum logic [1:0] {
    EBU_W8_UPPER = 2'b00,
    EBU_W8_LOWER = 2'b01,
    EBU_W16      = 2'b10,
    EBU_W_RSVD   = 2'b11
  } ebu_width_t;

  typedef enum logic [1:0] {
    EBU_SZ_WORD = 2'b00,
    EBU_SZ_BYTE = 2'b01,
    EBU_SZ_HALF = 2'b10,
    EBU_SZ_RSVD = 2'b11
  } ebu_size_t;

  typedef enum logic [1:0] {
    EBU_ST_IDLE = 2'b00,
    EBU_ST_ADDR = 2'b01,
    EBU_ST_BEAT = 2'b10,
    EBU_ST_DONE = 2'b11
  } ebu_state_t;

endpackage

/* core/ebu_lane_steer.sv */
// Lane steering of one bus cycle: lanes, bytes and low address bits.
// Assumes registered inputs from the bus unit on the same clock.
`timescale 1ns/1ns
`default_nettype none

module ebu_lane_steer
  import ebu_pkg::*;
(
  // Transfer description.
  input  wire ebu_size_t  size_i,
  input  wire logic [1:0] addr_lo_i,
  input  wire ebu_width_t width_i,
  input  wire logic [1:0] beat_i,
  // Steering of the current beat.
  output logic [2:0]      beats_o,
  output logic [1:0]      ext_addr_o,
  output logic            upper_en_o,
  output logic            lower_en_o,
  output logic [1:0]      upper_byte_o,
  output logic [1:0]      lower_byte_o
);

  logic [1:0] offset;

  always_comb begin
    // Each beat steps the low address by the port width.
    if (width_i == EBU_W16) begin
      offset = addr_lo_i + {beat_i[0], 1'b0};
    end else begin
      offset = addr_lo_i + beat_i;
    end
    ext_addr_o = offset;
    unique case (size_i)
      EBU_SZ_BYTE: beats_o = 3'h1;
      EBU_SZ_HALF: beats_o = (width_i == EBU_W16) ? 3'h1 : 3'h2;
      default:     beats_o = (width_i == EBU_W16) ? 3'h2 : 3'h4;
    endcase
    // Big-endian: byte 0 is internal bits 31 to 24.
    if (width_i == EBU_W16) begin
      if (size_i == EBU_SZ_BYTE) begin
        upper_en_o   = ~offset[0];
        lower_en_o   = offset[0];
        upper_byte_o = offset;
        lower_byte_o = offset;
      end else begin
        upper_en_o   = 1'b1;
        lower_en_o   = 1'b1;
        upper_byte_o = {offset[1], 1'b0};
        lower_byte_o = {offset[1], 1'b1};
      end
    end else begin
      upper_en_o   = (width_i == EBU_W8_UPPER);
      lower_en_o   = (width_i == EBU_W8_LOWER);
      upper_byte_o = offset;
      lower_byte_o = offset;
    end
  end

endmodule

`default_nettype wire

/* core/ebu_watchdog.sv */
// Bus watchdog: counts clocks of an access and flags a hung one.
// Assumes start and stop pulses from the bus unit on the same clock.
`timescale 1ns/1ns
`default_nettype none

module ebu_watchdog
(
  // Clock and reset.
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  // Access tracking.
  input  wire logic start_i,
  input  wire logic stop_i,
  output logic      expire_o
);

`include "ebu_regs.svh"

  logic       running;
  logic [7:0] count;

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      running <= 1'b0;
      count   <= 8'h00;
    end else if (start_i) begin
      running <= 1'b1;
      count   <= 8'h01;
    end else if (stop_i || expire_o) begin
      running <= 1'b0;
      count   <= 8'h00;
    end else if (running) begin
      count <= count + 8'h01;
    end
  end

  // The access started one clock before count is one.
  assign expire_o = running && (count == `EBU_WDOG_CLOCKS) && !stop_i;

endmodule

`default_nettype wire

/* tb/ebu_chk.sv */
// Checker on the ports of the external bus unit.
// Assumes it is bound into ebu_top on the core clock.
`timescale 1ns/1ns
`default_nettype none
module ebu_chk (
  // Watched ports.
  input wire logic        clock_i,
  input wire logic        rst_n_i,
  input wire logic        req_ready_o,
  input wire logic        ack_o,
  input wire logic        err_o,
  input wire logic        rom_enable_o,
  input wire logic [31:0] reset_vector_o,
  input wire logic [21:0] ext_addr_o,
  input wire logic [15:0] ext_data_o,
  input wire logic        ext_data_oe_o,
  input wire logic        read_write_n_o,
  input wire logic        output_enable_n_o,
  input wire logic        upper_lane_enable_n_o,
  input wire logic        lower_lane_enable_n_o,
  input wire logic [4:0]  chip_select_n_o,
  input wire logic        chip_select_five_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  logic [7:0] busy;
  logic       strobe;
  logic       lanes;
  assign strobe = !output_enable_n_o || !read_write_n_o;
  assign lanes = !upper_lane_enable_n_o || !lower_lane_enable_n_o;
  // Counts the cycles of one access.
  always_ff @(posedge clock_i) begin
    if (!rst_n_i || req_ready_o) busy <= 8'h00;
    else busy <= busy + 8'h01;
  end
  ////////////////////////////////////////////////////////////////
  a_reset_pins: assert property ($rose(rst_n_i) |-> read_write_n_o && output_enable_n_o
    && upper_lane_enable_n_o && lower_lane_enable_n_o && ext_addr_o == 22'h0
    && chip_select_n_o[4:1] == 4'hf && !chip_select_five_o) else $error("pins wrong after reset");
  a_read_strobe: assert property (!output_enable_n_o |-> read_write_n_o && !ext_data_oe_o)
    else $error("output enable outside a read");
  a_write_drive: assert property (!read_write_n_o |-> ext_data_oe_o && output_enable_n_o)
    else $error("write without data drive");
  a_lane_in_cycle: assert property (lanes |-> strobe)
    else $error("lane enable outside a bus cycle");
  a_done_ready: assert property ((ack_o || err_o) |=> req_ready_o && !ack_o && !err_o)
    else $error("answer not followed by idle");
  a_wdog_bound: assert property (!req_ready_o |-> busy <= 8'h80)
    else $error("access longer than watchdog");
  a_timeout_quiet: assert property (err_o |-> !strobe && !lanes)
    else $error("strobes left on at error");
  a_idle_hold: assert property (req_ready_o && $past(req_ready_o) |-> $stable(ext_addr_o) && $stable(ext_data_o))
    else $error("pins moved while idle");
  a_rom_single: assert property (!rom_enable_o |=> rom_enable_o)
    else $error("boot rom off too long");
  a_rom_vector: assert property (!rom_enable_o |-> !chip_select_n_o[0] && reset_vector_o == 32'h4000_0000)
    else $error("external boot wrong");
  c_ack: cover property (ack_o);
  c_err: cover property (err_o);
  c_boot_ext: cover property (!rom_enable_o);
endmodule
bind ebu_top ebu_chk u_chk (.clock_i(clock_i), .rst_n_i(rst_n_i), .req_ready_o(req_ready_o), .ack_o(ack_o),
  .err_o(err_o), .rom_enable_o(rom_enable_o), .reset_vector_o(reset_vector_o), .ext_addr_o(ext_addr_o),
  .ext_data_o(ext_data_o), .ext_data_oe_o(ext_data_oe_o), .read_write_n_o(read_write_n_o),
  .output_enable_n_o(output_enable_n_o), .upper_lane_enable_n_o(upper_lane_enable_n_o),
  .lower_lane_enable_n_o(lower_lane_enable_n_o), .chip_select_n_o(chip_select_n_o),
  .chip_select_five_o(chip_select_five_o));
`default_nettype wire

/* tb/ebu_mem_model.sv */
// Memory model on the external pins of the bus unit.
// Assumes the bench sets the port width and the answer delay.
`timescale 1ns/1ns
`default_nettype none
module ebu_mem_model
  import ebu_pkg::*;
(
  // Setup.
  input  wire logic        clock_i,
  input  wire ebu_width_t  width_i,
  input  wire logic [7:0]  delay_i,
  // Bus pins.
  input  wire logic [21:0] addr_i,
  input  wire logic [15:0] data_i,
  input  wire logic        rw_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        up_n_i,
  input  wire logic        lo_n_i,
  output logic [15:0]      data_o,
  output logic             ready_o
);
  logic [7:0]  mem [0:63];
  logic [7:0]  cnt = 8'h00;
  logic [15:0] idle = 16'h0000;
  logic [5:0]  hi;
  logic [5:0]  lo;
  logic        act;
  initial begin
    for (int i = 0; i < 64; i++) mem[i] = 8'(i * 7 + 3);
  end
  // Only low address bits decode, so high offsets alias.
  assign hi = (width_i == EBU_W16) ? {addr_i[5:1], 1'b0} : addr_i[5:0];
  assign lo = (width_i == EBU_W16) ? {addr_i[5:1], 1'b1} : addr_i[5:0];
  assign act = !up_n_i || !lo_n_i;
  assign ready_o = act && cnt >= delay_i;
  // Released lanes show the inverse of their last value.
  assign data_o[15:8] = (!oe_n_i && !up_n_i) ? mem[hi] : idle[15:8];
  assign data_o[7:0] = (!oe_n_i && !lo_n_i) ? mem[lo] : idle[7:0];
  always @(posedge clock_i) begin
    idle <= ~data_o;
    cnt <= !act ? 8'h00 : (cnt == 8'hff) ? cnt : cnt + 8'h01;
    if (!rw_n_i && ready_o && !up_n_i) mem[hi] <= data_i[15:8];
    if (!rw_n_i && ready_o && !lo_n_i) mem[lo] <= data_i[7:0];
  end
endmodule
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench of the external bus unit.
// Assumes the design and memory model compile first.
`timescale 1ns/1ns
`default_nettype none
module testbench import ebu_pkg::*;;
  logic        clock_i, rst_n_i, req_i, write_i, cfg_load_i, cfg_enable_i, cfg_gpo_i, boot_select_i;
  logic [31:0] addr_i, wdata_i, rdata_o, reset_vector_o;
  ebu_size_t   size_i;
  ebu_width_t  cfg_width_i, mwidth;
  logic [2:0]  cfg_sel_i;
  logic [3:0]  cfg_wait_i;
  logic [7:0]  mdelay;
  logic        req_ready_o, ack_o, err_o, rom_enable_o, ext_data_oe_o, ext_ready_i, read_write_n_o;
  logic        output_enable_n_o, upper_lane_enable_n_o, lower_lane_enable_n_o, chip_select_five_o;
  logic [21:0] ext_addr_o;
  logic [15:0] ext_data_i, ext_data_o;
  logic [4:0]  chip_select_n_o;
  logic [7:0]  tm [0:63];
  int          mismatches, total_checks, seed;
  ebu_top uut (.clock_i(clock_i), .rst_n_i(rst_n_i), .req_i(req_i), .addr_i(addr_i), .write_i(write_i),
    .size_i(size_i), .wdata_i(wdata_i), .req_ready_o(req_ready_o), .ack_o(ack_o), .err_o(err_o),
    .rdata_o(rdata_o), .cfg_load_i(cfg_load_i), .cfg_sel_i(cfg_sel_i), .cfg_enable_i(cfg_enable_i),
    .cfg_gpo_i(cfg_gpo_i), .cfg_width_i(cfg_width_i), .cfg_wait_i(cfg_wait_i), .boot_select_i(boot_select_i),
    .rom_enable_o(rom_enable_o), .reset_vector_o(reset_vector_o), .ext_addr_o(ext_addr_o),
    .ext_data_i(ext_data_i), .ext_data_o(ext_data_o), .ext_data_oe_o(ext_data_oe_o), .ext_ready_i(ext_ready_i),
    .read_write_n_o(read_write_n_o), .output_enable_n_o(output_enable_n_o),
    .upper_lane_enable_n_o(upper_lane_enable_n_o), .lower_lane_enable_n_o(lower_lane_enable_n_o),
    .chip_select_n_o(chip_select_n_o), .chip_select_five_o(chip_select_five_o));
  ebu_mem_model u_mem (.clock_i(clock_i), .width_i(mwidth), .delay_i(mdelay), .addr_i(ext_addr_o),
    .data_i(ext_data_o), .rw_n_i(read_write_n_o), .oe_n_i(output_enable_n_o), .up_n_i(upper_lane_enable_n_o),
    .lo_n_i(lower_lane_enable_n_o), .data_o(ext_data_i), .ready_o(ext_ready_i));
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end
  ////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic close_out;
    $display("mismatches %0d total_checks %0d", mismatches, total_checks);
    if (mismatches == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic cfg(input int s, input logic en, input logic gpo, input ebu_width_t w, input logic [3:0] ws);
    cfg_sel_i = 3'(s);
    cfg_enable_i = en;
    cfg_gpo_i = gpo;
    cfg_width_i = w;
    cfg_wait_i = ws;
    cfg_load_i = 1'b1;
    @(negedge clock_i);
    cfg_load_i = 1'b0;
    @(negedge clock_i);
  endtask
  task automatic do_reset(input logic boot);
    int low;
    low = 0;
    rst_n_i = 1'b0;
    boot_select_i = boot;
    repeat (20) @(negedge clock_i);
    rst_n_i = 1'b1;
    for (int i = 0; i < 4; i++) begin
      #1;
      if (rom_enable_o === 1'b0) low++;
      @(negedge clock_i);
    end
    check("rom off cycles", boot ? 0 : 1, low);
    check("vector", boot ? 32'h0 : 32'h4000_0000, reset_vector_o);
    check("idle pins", 32'h3ff, {ext_addr_o == 22'h0, read_write_n_o, output_enable_n_o, upper_lane_enable_n_o,
      lower_lane_enable_n_o, chip_select_n_o[4:1], !chip_select_five_o});
  endtask
  task automatic xfer(input logic [31:0] a, input logic wr, input ebu_size_t sz, output logic [31:0] rd,
                      output logic ok, output logic bad, output int cyc, output int nb, output logic [7:0] la,
                      output logic [5:0] pins);
    logic prev, on;
    prev = 0;
    {ok, bad, la, pins} = 16'h0000;
    {cyc, nb} = 64'h0;
    rd = 0;
    addr_i = a;
    write_i = wr;
    size_i = sz;
    wdata_i = $random(seed);
    req_i = 1'b1;
    @(negedge clock_i);
    req_i = 1'b0;
    while (ok !== 1'b1 && bad !== 1'b1 && cyc < 300) begin
      cyc++;
      on = upper_lane_enable_n_o === 1'b0 || lower_lane_enable_n_o === 1'b0;
      if (on && !prev) begin
        nb++;
        la = {la[5:0], ext_addr_o[1:0]};
        pins = {chip_select_five_o, chip_select_n_o};
      end
      prev = on;
      ok = ack_o;
      bad = err_o;
      if (ok === 1'b1) rd = rdata_o;
      @(negedge clock_i);
    end
    if (cyc >= 300) begin
      check("no answer", 0, 1);
      close_out;
    end
  endtask
  task automatic access(input logic [31:0] a, input logic wr, input ebu_size_t sz, input ebu_width_t w);
    logic [31:0] rd;
    logic        ok, bad;
    logic [7:0]  la, ela;
    logic [5:0]  pins;
    int          cyc, nb, n, l;
    n = (sz == EBU_SZ_BYTE) ? 1 : (sz == EBU_SZ_HALF) ? 2 : 4;
    xfer(a, wr, sz, rd, ok, bad, cyc, nb, la, pins);
    check("ack", 1, ok);
    check("beats", (w == EBU_W16) ? (n + 1) / 2 : n, nb);
    ela = 0;
    for (int i = 0; i < n; i++) begin
      l = a[1:0] + i;
      ela = {ela[5:0], 2'(l)};
      if (wr) tm[6'(a[5:0] + i)] = wdata_i[31 - 8 * l -: 8];
      else check("read byte", tm[6'(a[5:0] + i)], rd[31 - 8 * l -: 8]);
    end
    if (w != EBU_W16) check("low address", ela, la);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] rd;
    logic        ok, bad;
    logic [7:0]  la;
    logic [5:0]  pins;
    int          cyc, nb, off;
    ebu_size_t   sz;
    seed = 73;
    mismatches = 0;
    total_checks = 0;
    {rst_n_i, req_i, write_i, cfg_load_i, cfg_enable_i, cfg_gpo_i, boot_select_i, cfg_wait_i, mdelay} = 19'h00000;
    addr_i = 0;
    wdata_i = 0;
    size_i = EBU_SZ_WORD;
    cfg_sel_i = 0;
    cfg_width_i = EBU_W16;
    mwidth = EBU_W16;
    for (int i = 0; i < 64; i++) tm[i] = 8'(i * 7 + 3);
    do_reset(1'b1);
    do_reset(1'b0);
    xfer(32'h4000_0000, 0, EBU_SZ_WORD, rd, ok, bad, cyc, nb, la, pins);
    check("slow select zero", 1, ok && cyc >= 35 && nb == 2);
    for (int k = 0; k < 6; k++) begin
      cfg(k, 1, 0, EBU_W16, 0);
      xfer({8'h40 + 8'(k), 24'h10}, 0, EBU_SZ_BYTE, rd, ok, bad, cyc, nb, la, pins);
      check("select pins", (k == 5) ? 6'h3f : {1'b0, ~(5'h01 << k)}, pins);
    end
    for (int w = 0; w < 3; w++) begin
      mwidth = ebu_width_t'(w);
      mdelay = 8'($random(seed)) & 8'h03;
      cfg(1, 1, 0, mwidth, 4'($random(seed)) & 4'h3);
      for (int j = 0; j < 14; j++) begin
        sz = (j % 7 < 4) ? EBU_SZ_BYTE : (j % 7 < 6) ? EBU_SZ_HALF : EBU_SZ_WORD;
        off = (j % 7 < 4) ? j % 7 : (j % 7 < 6) ? 2 * (j % 7 - 4) : 0;
        access(32'h4100_0010 + off, j < 7, sz, mwidth);
      end
    end
    access(32'h4140_0025, 1, EBU_SZ_BYTE, mwidth);
    access(32'h4100_0025, 0, EBU_SZ_BYTE, mwidth);
    xfer(32'h5000_0000, 0, EBU_SZ_WORD, rd, ok, bad, cyc, nb, la, pins);
    check("unmapped timeout", 129, (bad === 1'b1) ? cyc : 0);
    mdelay = 8'hc8;
    xfer(32'h4100_0000, 1, EBU_SZ_WORD, rd, ok, bad, cyc, nb, la, pins);
    check("stall timeout", 129, (bad === 1'b1) ? cyc : 0);
    mdelay = 8'h01;
    access(32'h4100_0004, 0, EBU_SZ_WORD, mwidth);
    cfg(2, 0, 1, EBU_W16, 0);
    check("output pin", 1, chip_select_n_o[2]);
    cfg(3, 1, 0, EBU_W_RSVD, 0);
    for (int e = 0; e < 4; e++) begin
      xfer(e == 0 ? 32'h4200_0000 : e == 1 ? 32'h4300_0000 : 32'h4100_0001 + e, 0,
        e == 3 ? EBU_SZ_RSVD : EBU_SZ_HALF, rd, ok, bad, cyc, nb, la, pins);
      check("refused", 1, bad === 1'b1 && cyc == 1);
    end
    do_reset(1'b1);
    close_out;
  end
endmodule
`default_nettype wire
